// [hw/cer_clock_reset.v]
// Purpose: System clock source selection, instruction-rate divider and external reset sequence.
// Assumes: Oscillator outputs and the reset pin are sampled by mclk_in, so they must be slower
// Assumes: than half the 20 MHz sampling clock; faster sources are a limitation of this model.
// Notes: The instruction rate appears as a one-cycle tick, not as a generated clock.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "cer_consts.vh"

//Function
//- Pin resets only when reset option selected.
//- Reset pin low resets, high runs.
//- Pin honoured at power-up and while running.
//- Stay in reset until pin goes high.
//- Initialise all registers after pin release.
//- Wait oscillator warm-up, then deliver clock.
//- Then start fetching at address zero.
//- Option chooses internal or external fast source.
//- Software bit may select the slow oscillator.
//- Normal mode divides fast clock 1 to 16.
//- Slow mode divides slow clock by four.
//- Filter on limits divider to four.
//- Filter suppresses glitches on external oscillator.
//- Slow select zero normal, one slow.
module cer_clock_reset #(
	parameter WARMUP_EDGES = `CER_WARMUP_EDGES
) (
	input wire mclk_in,
	input wire reset_n_in,
	input wire reset_pin_enable_in,
	input wire ext_reset_n_in,
	input wire [2:0] fast_osc_select_in,
	input wire [2:0] cpu_div_select_in,
	input wire noise_filter_enable_in,
	input wire internal_fast_rc_in,
	input wire ext_osc_in,
	input wire internal_slow_rc_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_write_in,
	input wire reg_read_in,
	output reg [7:0] reg_rdata_out,
	output reg sys_reset_n_out,
	output reg reg_init_out,
	output reg sys_clock_enable_out,
	output reg fetch_start_out,
	output reg [11:0] fetch_addr_out,
	output reg fcpu_tick_out,
	output reg slow_mode_out
);

	// Sequencer states, one-hot.
	localparam ST_WAIT_PIN = 4'b0001;
	localparam ST_INIT = 4'b0010;
	localparam ST_WARMUP = 4'b0100;
	localparam ST_RUN = 4'b1000;

	// Number of asynchronous inputs that pass through a synchroniser.
	localparam NSYNC = 4;

	// Asynchronous inputs gathered into one vector for the synchroniser loop.
	wire [NSYNC-1:0] async_in;
	// Synchroniser first stage; only the second stage reads it.
	reg [NSYNC-1:0] sync_meta;
	// Synchroniser second stage; the first place logic may look.
	reg [NSYNC-1:0] sync_stable;
	// One more stage for edge detection on the oscillator samples.
	reg [NSYNC-1:0] sync_prev;

	// Sequencer state register and its next value.
	reg [3:0] state;
	reg [3:0] next_state;
	// Warm-up counter of slow oscillator edges.
	reg [11:0] warmup_count;
	// Oscillator control register fields.
	reg stop_fast;
	reg slow_clock_select;
	reg [1:0] cpu_mode;
	// Filtered external oscillator level and its stability counter.
	reg ext_filtered;
	reg [1:0] filter_count;
	reg ext_filtered_prev;
	// Instruction divider counter.
	reg [4:0] div_count;

	// Decoded helpers.
	wire pin_low;
	wire use_internal_fast;
	wire fast_raw_edge;
	wire ext_filt_edge;
	wire fast_edge;
	wire slow_edge;
	wire src_edge;
	wire [2:0] div_code_clamped;
	wire [2:0] div_code_eff;
	wire [4:0] fast_divide;
	wire [4:0] divide;

	assign async_in = {internal_slow_rc_in, ext_osc_in, internal_fast_rc_in, ext_reset_n_in};

	// Two-flop synchronisers for every pin that comes from outside the clock domain.
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1)
		begin : g_sync
			always @(posedge mclk_in)
			begin
				if (!reset_n_in)
				begin
					// Reset pin samples idle high so a released pin does not look asserted.
					sync_meta[gi] <= (gi == 0) ? 1'b1 : 1'b0;
					sync_stable[gi] <= (gi == 0) ? 1'b1 : 1'b0;
					sync_prev[gi] <= (gi == 0) ? 1'b1 : 1'b0;
				end
				else
				begin
					sync_meta[gi] <= async_in[gi];
					sync_stable[gi] <= sync_meta[gi];
					sync_prev[gi] <= sync_stable[gi];
				end
			end
		end
	endgenerate

	// The pin counts only when the option selects the reset function; low is reset.
	assign pin_low = reset_pin_enable_in && !sync_stable[0];

	// Source choice: code zero is the internal fast RC, every other code an external type.
	assign use_internal_fast = (fast_osc_select_in == `CER_SRC_INT_FAST_RC);
	assign fast_raw_edge = sync_stable[1] && !sync_prev[1];
	assign ext_filt_edge = ext_filtered && !ext_filtered_prev;
	// The filter only sits on the external path; the internal RC is clean already.
	assign fast_edge = !stop_fast &&
		(use_internal_fast ? fast_raw_edge : (noise_filter_enable_in ? ext_filt_edge :
		(sync_stable[2] && !sync_prev[2])));
	assign slow_edge = sync_stable[3] && !sync_prev[3];

	// Slow select bit: zero keeps the fast clock, one feeds the slow RC to the divider.
	assign src_edge = slow_clock_select ? slow_edge : fast_edge;

	// Codes above 4 are treated as 4 (ratio 16) so the divider never overruns its counter.
	assign div_code_clamped = (cpu_div_select_in > `CER_DIV_CODE_MAX) ?
		`CER_DIV_CODE_MAX : cpu_div_select_in;
	// With the filter on the ratio is held at four or less.
	assign div_code_eff = (noise_filter_enable_in && (div_code_clamped > `CER_DIV_CODE_FILTER_MAX))
		? `CER_DIV_CODE_FILTER_MAX : div_code_clamped;
	assign fast_divide = 5'h01 << div_code_eff;
	// Slow mode ignores the divider option altogether.
	assign divide = slow_clock_select ? `CER_SLOW_DIVIDE : fast_divide;

	// Glitch filter: a new external level is accepted only after it stands for a few samples.
	// This trades a small fixed delay on each edge for immunity to short spikes.
	always @(posedge mclk_in)
	begin
		if (!reset_n_in)
		begin
			ext_filtered <= 1'b0;
			ext_filtered_prev <= 1'b0;
			filter_count <= 2'h0;
		end
		else
		begin
			ext_filtered_prev <= ext_filtered;
			if (sync_stable[2] == ext_filtered)
			begin
				// Level agrees with the accepted one; restart the stability count.
				filter_count <= 2'h0;
			end
			else if (filter_count == `CER_FILTER_SAMPLES - 2'h1)
			begin
				// Level held long enough; accept it.
				ext_filtered <= sync_stable[2];
				filter_count <= 2'h0;
			end
			else
			begin
				// Still unproven; keep counting.
				filter_count <= filter_count + 2'h1;
			end
		end
	end

	// Next-state logic of the reset sequencer.
	always @*
	begin
		next_state = state;
		case (state)
			ST_WAIT_PIN:
			begin
				// Hold here while the pin is still low.
				if (!pin_low)
				begin
					next_state = ST_INIT;
				end
			end
			ST_INIT:
			begin
				// One cycle of register initialisation, then warm-up.
				next_state = ST_WARMUP;
			end
			ST_WARMUP:
			begin
				if (slow_edge && (warmup_count == WARMUP_EDGES - 1))
				begin
					next_state = ST_RUN;
				end
			end
			ST_RUN:
			begin
				next_state = ST_RUN;
			end
			default:
			begin
				next_state = ST_WAIT_PIN;
			end
		endcase
		// A low pin overrides every state, during power-up and in normal running.
		if (pin_low)
		begin
			next_state = ST_WAIT_PIN;
		end
	end

	// Sequencer registers and its registered outputs.
	always @(posedge mclk_in)
	begin
		if (!reset_n_in)
		begin
			state <= ST_WAIT_PIN;
			warmup_count <= 12'h000;
			sys_reset_n_out <= 1'b0;
			reg_init_out <= 1'b0;
			sys_clock_enable_out <= 1'b0;
			fetch_start_out <= 1'b0;
			fetch_addr_out <= 12'h000;
		end
		else
		begin
			state <= next_state;
			// Warm-up counts slow oscillator edges only while warming up.
			if (state != ST_WARMUP)
			begin
				warmup_count <= 12'h000;
			end
			else if (slow_edge)
			begin
				warmup_count <= warmup_count + 12'h001;
			end
			// System reset is released only in the cycle the sequencer reaches run.
			sys_reset_n_out <= (next_state == ST_RUN);
			reg_init_out <= (next_state == ST_INIT);
			sys_clock_enable_out <= (next_state == ST_RUN);
			// Fetch starts once, at address zero, on entry into run.
			fetch_start_out <= (next_state == ST_RUN) && (state != ST_RUN);
			fetch_addr_out <= 12'h000;
		end
	end

	// Oscillator control register; cleared by power reset and again during initialisation.
	always @(posedge mclk_in)
	begin
		if (!reset_n_in || (state == ST_INIT))
		begin
			{cpu_mode, slow_clock_select, stop_fast} <= `CER_OSC_CTRL_RST;
		end
		else if (reg_write_in && (reg_addr_in == `CER_OSC_CTRL_ADDR) && (state == ST_RUN))
		begin
			// Software may change the mode only once the system runs.
			stop_fast <= reg_wdata_in[`CER_STOP_FAST_BIT];
			slow_clock_select <= reg_wdata_in[`CER_SLOW_SEL_BIT];
			cpu_mode <= reg_wdata_in[`CER_CPU_MODE_HI:`CER_CPU_MODE_LO];
		end
	end

	// Instruction-rate divider: one tick per divide source edges, only while running.
	always @(posedge mclk_in)
	begin
		if (!reset_n_in || (state != ST_RUN))
		begin
			div_count <= 5'h00;
			fcpu_tick_out <= 1'b0;
			slow_mode_out <= 1'b0;
		end
		else
		begin
			slow_mode_out <= slow_clock_select;
			fcpu_tick_out <= 1'b0;
			if (src_edge)
			begin
				if (div_count >= divide - 5'h01)
				begin
					// Last edge of the period; emit the tick and restart.
					div_count <= 5'h00;
					fcpu_tick_out <= 1'b1;
				end
				else
				begin
					div_count <= div_count + 5'h01;
				end
			end
		end
	end

	// Read port: data stand in the cycle after the read strobe and only then.
	always @(posedge mclk_in)
	begin
		if (!reset_n_in)
		begin
			reg_rdata_out <= 8'h00;
		end
		else if (reg_read_in)
		begin
			case (reg_addr_in)
				`CER_OSC_CTRL_ADDR:
				begin
					// Unused bits read as zero.
					reg_rdata_out <= {3'h0, cpu_mode, slow_clock_select, stop_fast, 1'b0};
				end
				`CER_STATUS_ADDR:
				begin
					// Sequencer state in the low nibble, live pin level above it.
					reg_rdata_out <= {3'h0, sync_stable[0], state};
				end
				default:
				begin
					// Unmapped addresses read as zero.
					reg_rdata_out <= 8'h00;
				end
			endcase
		end
		else
		begin
			reg_rdata_out <= 8'h00;
		end
	end

endmodule

// [hw/cer_consts.vh]
// Purpose: Constants for the clock selection and external reset sequencing block.
// Assumes: Included by cer_clock_reset.v only.
// Notes: Offsets are byte addresses on the plain register port.
`ifndef CER_CONSTS_VH
`define CER_CONSTS_VH

// Register offsets on the 8-bit register port.
`define CER_OSC_CTRL_ADDR 8'hCA
`define CER_STATUS_ADDR 8'hCB

// Field positions inside the oscillator control register.
`define CER_STOP_FAST_BIT 1
`define CER_SLOW_SEL_BIT 2
`define CER_CPU_MODE_LO 3
`define CER_CPU_MODE_HI 4

// Reset value of the writable oscillator control bits [4:1].
`define CER_OSC_CTRL_RST 4'h0

// Fast source selection codes.
`define CER_SRC_INT_FAST_RC 3'h0
`define CER_SRC_EXT_RC 3'h1
`define CER_SRC_XTAL_32K 3'h2
`define CER_SRC_XTAL_12M 3'h3
`define CER_SRC_XTAL_4M 3'h4

// Divider selection codes: ratio is 2 to the power of the code, 1 to 16.
`define CER_DIV_CODE_MAX 3'h4
`define CER_DIV_CODE_FILTER_MAX 3'h2
`define CER_SLOW_DIVIDE 5'h04

// Warm-up length in slow oscillator edges.
`define CER_WARMUP_EDGES 2048

// Samples for which the external oscillator must be stable to pass the filter.
`define CER_FILTER_SAMPLES 2'h2

`endif

// [test/cer_clock_reset_chk.sv]
// Purpose: Port checks for the clock selection and reset sequencing block.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Pin checks leave room for the two-stage pin synchroniser.
`timescale 1ns/10ps
module cer_clock_reset_chk #(
	parameter WARMUP_EDGES = 4
) (
	input wire mclk_in,
	input wire reset_n_in,
	input wire reset_pin_enable_in,
	input wire ext_reset_n_in,
	input wire sys_reset_n_out,
	input wire reg_init_out,
	input wire sys_clock_enable_out,
	input wire fetch_start_out,
	input wire [11:0] fetch_addr_out,
	input wire fcpu_tick_out,
	input wire slow_mode_out
);
	// Every check shares the one clock and sleeps during reset.
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!reset_n_in);
	pin_off_ignored_a: assert property (sys_reset_n_out && !reset_pin_enable_in |=>
		sys_reset_n_out) else $error("Run left with the pin disabled");
	pin_low_resets_a: assert property ((reset_pin_enable_in && !ext_reset_n_in)[*5]
		|-> !sys_reset_n_out) else $error("Low pin did not hold reset");
	held_in_reset_a: assert property ((reset_pin_enable_in && !ext_reset_n_in)[*3]
		##0 !sys_reset_n_out |=> !sys_reset_n_out) else $error("Left reset with pin low");
	init_pulse_a: assert property (reg_init_out |-> !sys_reset_n_out ##1
		!reg_init_out) else $error("Register init pulse wrong");
	warmup_wait_a: assert property (reg_init_out |=> !sys_clock_enable_out[*8])
		else $error("Clock delivered before warm-up");
	run_entry_a: assert property ($rose(sys_reset_n_out) |-> fetch_start_out &&
		sys_clock_enable_out && fetch_addr_out == 12'h000) else $error("Bad run entry");
	tick_idle_a: assert property (!sys_clock_enable_out[*2] |-> !fcpu_tick_out)
		else $error("Instruction tick outside run");
	slow_idle_a: assert property (!sys_reset_n_out[*2] |-> !slow_mode_out)
		else $error("Slow mode shown in reset");
endmodule

bind cer_clock_reset cer_clock_reset_chk #(.WARMUP_EDGES(WARMUP_EDGES)) chk_u (
	.mclk_in(mclk_in), .reset_n_in(reset_n_in), .reset_pin_enable_in(reset_pin_enable_in),
	.ext_reset_n_in(ext_reset_n_in), .sys_reset_n_out(sys_reset_n_out),
	.reg_init_out(reg_init_out), .sys_clock_enable_out(sys_clock_enable_out),
	.fetch_start_out(fetch_start_out), .fetch_addr_out(fetch_addr_out),
	.fcpu_tick_out(fcpu_tick_out), .slow_mode_out(slow_mode_out));

// [test/cer_clock_reset_tb.sv]
// Purpose: Self-checking bench for the clock selection and reset block.
// Assumes: Oscillators are slow square waves made from the 20 MHz clock.
// Notes: Warm-up is cut to 4 slow edges so the run stays short.
`timescale 1ns/10ps
module cer_clock_reset_tb;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic reset_pin_enable_in = 1'b1;
	logic ext_reset_n_in;
	logic fault = 1'b1; // Supply fault seen by the supervisor.
	logic glitch = 1'b0; // Swaps the external oscillator for short spikes.
	logic [2:0] fast_osc_select_in = 3'h0;
	logic [2:0] cpu_div_select_in = 3'h0;
	logic noise_filter_enable_in = 1'b0;
	logic internal_fast_rc_in = 1'b0;
	logic ext_osc_in = 1'b0;
	logic internal_slow_rc_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_write_in = 1'b0;
	logic reg_read_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic sys_reset_n_out, reg_init_out, sys_clock_enable_out, fetch_start_out;
	logic [11:0] fetch_addr_out;
	logic fcpu_tick_out, slow_mode_out;
	int phase = 0;
	int miscompares = 0;
	int compares = 0;
	int n, c;

	always #25 mclk_in = ~mclk_in;

	// Sources: fast RC 8 cycles, external 10 cycles, slow RC 12 cycles a period.
	always @(posedge mclk_in)
	begin
		phase <= phase + 1;
		internal_fast_rc_in <= (phase % 8) < 4;
		ext_osc_in <= glitch ? (phase % 6 == 0) : ((phase % 10) < 5);
		internal_slow_rc_in <= (phase % 12) < 6;
	end

	cer_reset_source src_u (.mclk_in(mclk_in), .fault_in(fault), .reset_n_out(ext_reset_n_in));

	cer_clock_reset #(.WARMUP_EDGES(4)) dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.reset_pin_enable_in(reset_pin_enable_in), .ext_reset_n_in(ext_reset_n_in),
		.fast_osc_select_in(fast_osc_select_in), .cpu_div_select_in(cpu_div_select_in),
		.noise_filter_enable_in(noise_filter_enable_in),
		.internal_fast_rc_in(internal_fast_rc_in), .ext_osc_in(ext_osc_in),
		.internal_slow_rc_in(internal_slow_rc_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
		.reg_rdata_out(reg_rdata_out), .sys_reset_n_out(sys_reset_n_out),
		.reg_init_out(reg_init_out), .sys_clock_enable_out(sys_clock_enable_out),
		.fetch_start_out(fetch_start_out), .fetch_addr_out(fetch_addr_out),
		.fcpu_tick_out(fcpu_tick_out), .slow_mode_out(slow_mode_out));

	// Wide enough for the run-entry word: start, clock enable and the 12-bit fetch address.
	task check(input logic [15:0] seen, input logic [15:0] exp);
	begin
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= 1'b1;
		@(posedge mclk_in);
		reg_write_in <= 1'b0;
	end
	endtask

	// Read data stand only in the cycle after the strobe, so sample just then.
	task rd(input logic [7:0] a, input logic [7:0] exp);
	begin
		@(posedge mclk_in);
		reg_addr_in <= a;
		reg_read_in <= 1'b1;
		@(posedge mclk_in);
		reg_read_in <= 1'b0;
		#1;
		check(reg_rdata_out, exp);
	end
	endtask

	// Counts edges up to the next tick; bounded so a dead divider cannot hang.
	task automatic wait_tick(output int k);
	begin
		k = 0;
		do
		begin
			@(posedge mclk_in);
			#1;
			k++;
		end
		while (!fcpu_tick_out && k < 600);
	end
	endtask

	// The first two ticks may straddle a divider change, so the third is timed.
	task automatic measure(input int exp);
		int k;
	begin
		wait_tick(k);
		wait_tick(k);
		wait_tick(k);
		check(k, exp);
	end
	endtask

	// Waits for a run entry and checks how it looks.
	task wait_run();
	begin
		for (n = 0; n < 500 && !fetch_start_out; n++)
			@(posedge mclk_in) #1;
		check({fetch_start_out, sys_clock_enable_out, fetch_addr_out}, 16'h3000);
	end
	endtask

	task close_out();
	begin
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask

	initial
	begin
		repeat (20000) @(posedge mclk_in);
		miscompares++;
		close_out();
	end

	initial
	begin
		repeat (3) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		repeat (10) @(posedge mclk_in);
		#1;
		check(sys_reset_n_out, 1'b0);
		rd(8'hCB, 8'h01);
		wr(8'hCA, 8'h04);
		rd(8'hCA, 8'h00);
		fault <= 1'b0;
		for (n = 0; n < 100 && !reg_init_out; n++)
			@(posedge mclk_in) #1;
		check({reg_init_out, sys_clock_enable_out}, 2'b10);
		wait_run();
		rd(8'hCB, 8'h18);
		for (c = 0; c < 5; c++)
		begin
			@(posedge mclk_in);
			cpu_div_select_in <= c[2:0];
			measure(8 << c);
		end
		@(posedge mclk_in);
		fast_osc_select_in <= 3'h4;
		cpu_div_select_in <= 3'h1;
		measure(20);
		@(posedge mclk_in);
		noise_filter_enable_in <= 1'b1;
		cpu_div_select_in <= 3'h4;
		measure(40);
		@(posedge mclk_in);
		cpu_div_select_in <= 3'h2;
		glitch <= 1'b1;
		repeat (20) @(posedge mclk_in);
		n = 0;
		repeat (80) @(posedge mclk_in) #1 n += fcpu_tick_out;
		check(n, 0);
		@(posedge mclk_in);
		glitch <= 1'b0;
		fast_osc_select_in <= 3'h0;
		wr(8'hCA, 8'h04);
		rd(8'hCA, 8'h04);
		check(slow_mode_out, 1'b1);
		measure(48);
		wr(8'hCA, 8'h00);
		rd(8'h10, 8'h00);
		check(slow_mode_out, 1'b0);
		// The stop bit must silence the fast source, so no tick may appear.
		wr(8'hCA, 8'h02);
		rd(8'hCA, 8'h02);
		n = 0;
		repeat (64) @(posedge mclk_in) #1 n += fcpu_tick_out;
		check(n, 0);
		wr(8'hCA, 8'h00);
		fault <= 1'b1;
		repeat (10) @(posedge mclk_in);
		#1;
		check(sys_reset_n_out, 1'b0);
		fault <= 1'b0;
		wait_run();
		@(posedge mclk_in);
		reset_pin_enable_in <= 1'b0;
		fault <= 1'b1;
		repeat (20) @(posedge mclk_in);
		#1;
		check(sys_reset_n_out, 1'b1);
		close_out();
	end
endmodule

// [test/cer_reset_source.sv]
// Purpose: External reset supervisor that drives the reset pin.
// Assumes: A supply fault request from the bench stands for a brown-out.
// Notes: The pin stays low a few cycles after the fault clears, as a supervisor would.
`timescale 1ns/10ps
module cer_reset_source #(
	parameter HOLD = 6
) (
	input wire mclk_in,
	input wire fault_in,
	output logic reset_n_out
);
	int hold_cnt = 0; // Cycles of low output still owed after a fault.
	initial reset_n_out = 1'b0;
	// Low while the fault stands, then high after the hold so the device may run.
	always @(posedge mclk_in)
	begin
		if (fault_in)
		begin
			hold_cnt <= HOLD;
			reset_n_out <= 1'b0;
		end
		else if (hold_cnt > 0)
			hold_cnt <= hold_cnt - 1;
		else
			reset_n_out <= 1'b1;
	end
endmodule
